// ### design/ctu_pkg.sv
package ctu_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [11:0] CTU_IDX_EDGE_CONTROL_LOW = 12'hFB2;
   localparam logic [11:0] CTU_IDX_UNIT_CONTROL_HIGH = 12'hFB3;
   localparam logic [13:0] CTU_ADDR_EDGE_CONTROL_LOW = {CTU_IDX_EDGE_CONTROL_LOW, 2'b00};
   localparam logic [13:0] CTU_ADDR_UNIT_CONTROL_HIGH = {CTU_IDX_UNIT_CONTROL_HIGH, 2'b00};
   localparam int CTU_ADDR_W = 14;
   localparam logic [7:0] CTU_RESET_VALUE = 8'h00;
   // high control register fields
   localparam int CTU_HI_ENABLE = 7;
   localparam int CTU_HI_STOP_IDLE = 5;
   localparam int CTU_HI_DELAY_GEN = 4;
   localparam int CTU_HI_EDGE_PASS = 3;
   localparam int CTU_HI_EDGE_ORDER = 2;
   localparam int CTU_HI_DISCHARGE = 1;
   localparam logic [7:0] CTU_HI_WRITE_MASK = 8'hBE;
   // low control register fields
   localparam int CTU_LO_SECOND_POL = 7;
   localparam int CTU_LO_SECOND_SRC = 5;
   localparam int CTU_LO_FIRST_POL = 4;
   localparam int CTU_LO_FIRST_SRC = 2;
   localparam int CTU_LO_SECOND_FLAG = 1;
   localparam int CTU_LO_FIRST_FLAG = 0;
   // edge source encoding
   localparam logic [1:0] CTU_SRC_INPUT_A = 2'h3;
   localparam logic [1:0] CTU_SRC_INPUT_B = 2'h2;
   localparam logic [1:0] CTU_SRC_CMP_FIRST = 2'h1;
   localparam logic [1:0] CTU_SRC_CMP_SECOND = 2'h0;
   typedef enum logic [1:0] {
      CTU_PULSE_IDLE = 2'b00,
      CTU_PULSE_ARMED = 2'b01,
      CTU_PULSE_FIRE = 2'b11
   } ctu_pulse_state_t;
endpackage

// ### design/ctu_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
// picks one of four sources and flags the selected edge of it
module ctu_edge_detect
   import ctu_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] sources,
   input wire logic [1:0] select,
   input wire logic rising,
   output logic edge_seen
);
   typedef struct packed {
      logic [3:0] prev;
   } ctu_edge_state_t;

   ctu_edge_state_t state_reg;
   ctu_edge_state_t state_next;
   logic now_level;
   logic old_level;

   always_comb begin
      state_next.prev = sources;
      now_level = sources[select];
      old_level = state_reg.prev[select];
      edge_seen = rising ? (now_level && !old_level) : (!now_level && old_level);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule
`default_nettype wire

// ### design/ctu_charge_time_unit.sv
`timescale 1ns/1ns
`default_nettype none
module ctu_charge_time_unit
   import ctu_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic EDGE_INPUT_A,
   input wire logic EDGE_INPUT_B,
   input wire logic COMPARE_UNIT_FIRST_TRIGGER,
   input wire logic COMPARE_UNIT_SECOND_TRIGGER,
   input wire logic COMPARATOR_TRIP,
   input wire logic SLEEP_MODE,
   input wire logic IDLE_MODE,
   output logic CHARGE_ENABLE,
   output logic SOURCE_GROUND,
   output logic PULSE_OUT_PIN
);
   typedef struct packed {
      logic [7:0] ctrl_high;
      logic [7:0] ctrl_low;
      ctu_pulse_state_t pulse_state;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic charge;
      logic ground;
      logic pulse;
   } ctu_state_t;

   ctu_state_t state_reg;
   ctu_state_t state_next;
   logic first_edge;
   logic second_edge;
   logic [3:0] sources;
   logic unit_on;
   logic source_allowed;
   logic access;
   logic hit_low;
   logic hit_high;
   logic first_set;
   logic second_set;
   logic [7:0] wval;

   function automatic logic [7:0] merge_byte(input logic [7:0] old_val,
         input logic [31:0] wdata, input logic [3:0] strb);
      merge_byte = strb[0] ? wdata[7:0] : old_val;
   endfunction

   // index order matches the source encoding
   assign sources = {EDGE_INPUT_A, EDGE_INPUT_B,
                     COMPARE_UNIT_FIRST_TRIGGER, COMPARE_UNIT_SECOND_TRIGGER};

   ctu_edge_detect first_det (
      .clk(SYS_CLK),
      .rst(RST),
      .sources(sources),
      .select(state_reg.ctrl_low[CTU_LO_FIRST_SRC +: 2]),
      .rising(state_reg.ctrl_low[CTU_LO_FIRST_POL]),
      .edge_seen(first_edge)
   );

   ctu_edge_detect second_det (
      .clk(SYS_CLK),
      .rst(RST),
      .sources(sources),
      .select(state_reg.ctrl_low[CTU_LO_SECOND_SRC +: 2]),
      .rising(state_reg.ctrl_low[CTU_LO_SECOND_POL]),
      .edge_seen(second_edge)
   );

   always_comb begin
      state_next = state_reg;
      unit_on = state_reg.ctrl_high[CTU_HI_ENABLE];
      // sleep always wins; idle only stops the source when asked to
      source_allowed = unit_on && !SLEEP_MODE
         && !(IDLE_MODE && state_reg.ctrl_high[CTU_HI_STOP_IDLE]);
      access = PSEL && PENABLE && !state_reg.ready;
      hit_low = PADDR[CTU_ADDR_W-1:0] == CTU_ADDR_EDGE_CONTROL_LOW
                && PADDR[31:CTU_ADDR_W] == '0;
      hit_high = PADDR[CTU_ADDR_W-1:0] == CTU_ADDR_UNIT_CONTROL_HIGH
                 && PADDR[31:CTU_ADDR_W] == '0;
      wval = 8'h00;

      // one wait state per access: ready pulses the cycle after the access phase starts
      state_next.ready = access;
      state_next.slverr = access && !(hit_low || hit_high);
      state_next.rdata = 32'h0000_0000;
      if (access && !PWRITE) begin
         if (hit_low) begin
            state_next.rdata = {24'h00_0000, state_reg.ctrl_low};
         end else if (hit_high) begin
            state_next.rdata = {24'h00_0000, state_reg.ctrl_high};
         end
      end
      if (access && PWRITE && hit_high) begin
         wval = merge_byte(state_reg.ctrl_high, PWDATA, PSTRB);
         state_next.ctrl_high = wval & CTU_HI_WRITE_MASK;
      end
      if (access && PWRITE && hit_low) begin
         state_next.ctrl_low = merge_byte(state_reg.ctrl_low, PWDATA, PSTRB);
      end

      // hardware edges set flags after any software write; set wins
      first_set = unit_on && state_reg.ctrl_high[CTU_HI_EDGE_PASS] && first_edge;
      second_set = unit_on && state_reg.ctrl_high[CTU_HI_EDGE_PASS] && second_edge
         && (!state_reg.ctrl_high[CTU_HI_EDGE_ORDER]
             || state_reg.ctrl_low[CTU_LO_FIRST_FLAG] || first_set);
      if (first_set) begin
         state_next.ctrl_low[CTU_LO_FIRST_FLAG] = 1'b1;
      end
      if (second_set) begin
         state_next.ctrl_low[CTU_LO_SECOND_FLAG] = 1'b1;
      end

      state_next.charge = source_allowed && state_next.ctrl_low[CTU_LO_FIRST_FLAG]
         && !state_next.ctrl_low[CTU_LO_SECOND_FLAG];
      state_next.ground = unit_on && state_next.ctrl_high[CTU_HI_DISCHARGE];

      // pulse delay: arm on first flag, fire on comparator trip
      case (state_reg.pulse_state)
         CTU_PULSE_IDLE: begin
            state_next.pulse = 1'b0;
            if (unit_on && state_reg.ctrl_high[CTU_HI_DELAY_GEN]
                && state_reg.ctrl_low[CTU_LO_FIRST_FLAG]) begin
               state_next.pulse_state = CTU_PULSE_ARMED;
            end
         end
         CTU_PULSE_ARMED: begin
            if (!unit_on || !state_reg.ctrl_high[CTU_HI_DELAY_GEN]) begin
               state_next.pulse_state = CTU_PULSE_IDLE;
            end else if (COMPARATOR_TRIP) begin
               state_next.pulse = 1'b1;
               state_next.pulse_state = CTU_PULSE_FIRE;
            end
         end
         CTU_PULSE_FIRE: begin
            // pulse holds until software drops the first flag, the delay generator enable or the unit enable
            state_next.pulse = unit_on && state_reg.ctrl_high[CTU_HI_DELAY_GEN]
               && state_reg.ctrl_low[CTU_LO_FIRST_FLAG];
            if (!state_next.pulse) begin
               state_next.pulse_state = CTU_PULSE_IDLE;
            end
         end
         default: begin
            state_next.pulse = 1'b0;
            state_next.pulse_state = CTU_PULSE_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         // everything cleared, any measurement is lost
         state_reg <= '0;
         state_reg.ctrl_high <= CTU_RESET_VALUE;
         state_reg.ctrl_low <= CTU_RESET_VALUE;
         state_reg.pulse_state <= CTU_PULSE_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign PRDATA = state_reg.rdata;
   assign PREADY = state_reg.ready;
   assign PSLVERR = state_reg.slverr;
   assign CHARGE_ENABLE = state_reg.charge;
   assign SOURCE_GROUND = state_reg.ground;
   assign PULSE_OUT_PIN = state_reg.pulse;
endmodule
`default_nettype wire

// ### bench/ctu_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ctu_chk (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [31:0] PRDATA,
   input wire logic SLEEP_MODE,
   input wire logic COMPARATOR_TRIP,
   input wire logic CHARGE_ENABLE,
   input wire logic PULSE_OUT_PIN
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   sequence access_s; PSEL && PENABLE && !PREADY; endsequence
   sequence answer_s; PREADY ##1 !PREADY; endsequence
   reset_clear_a: assert property ($fell(RST) |-> !CHARGE_ENABLE && !PULSE_OUT_PIN)
      else $error("outputs not clear");
   sleep_off_a: assert property (SLEEP_MODE |=> !CHARGE_ENABLE) else $error("sleep");
   sleep_rise_a: assert property ($rose(CHARGE_ENABLE) |-> !$past(SLEEP_MODE))
      else $error("charge in sleep");
   pulse_trip_a: assert property ($rose(PULSE_OUT_PIN) |-> $past(COMPARATOR_TRIP))
      else $error("pulse without trip");
   pulse_end_a: assert property ($fell(PULSE_OUT_PIN) |-> $past(PREADY) || $past(PREADY, 2))
      else $error("pulse end");
   ready_time_a: assert property (access_s |=> answer_s) else $error("ready");
   err_ready_a: assert property (PSLVERR |-> PREADY && PRDATA == 0) else $error("slverr");
   rd_width_a: assert property (PREADY |-> PRDATA[31:8] == 0) else $error("width");
endmodule
bind ctu_charge_time_unit ctu_chk chk_u (.*);
`default_nettype wire

// ### bench/ctu_edge_model.sv
`timescale 1ns/1ns
`default_nettype none
// edge pins, plus a capacitor that trips the comparator after charging a while
module ctu_edge_model #(parameter int TRIP_CYCLES = 4) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] toggle,
   input wire logic charge,
   input wire logic ground,
   output logic [3:0] lines,
   output logic trip
);
   int lvl;
   assign trip = lvl >= TRIP_CYCLES;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lines <= 4'h0;
         lvl <= 0;
      end else begin
         lines <= lines ^ toggle;
         if (ground) lvl <= 0;
         else if (charge && !trip) lvl <= lvl + 1;
      end
   end
endmodule
`default_nettype wire

// ### bench/charge_time_edge_control_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_charge_time_edge_control import ctu_pkg::*;;
   logic SYS_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, se, p;
   logic [31:0] PADDR = 0, PWDATA = 0, PRDATA;
   logic [3:0] PSTRB = 4'hF, tog = 0, lines;
   logic PREADY, PSLVERR, CHARGE_ENABLE, SOURCE_GROUND, PULSE_OUT_PIN, COMPARATOR_TRIP;
   logic SLEEP_MODE = 0, IDLE_MODE = 0;
   logic [7:0] rv, w;
   logic [15:0] rows [8] = '{16'h1C1D, 16'h0809, 16'h1415, 16'h6061,
      16'h6163, 16'hC1C3, 16'h2123, 16'h8183};
   int err_count = 0, checked = 0, cyc = 0, s;
   localparam logic [13:0] LO = CTU_ADDR_EDGE_CONTROL_LOW, HI = CTU_ADDR_UNIT_CONTROL_HIGH;
   ctu_charge_time_unit dut_u (.*, .EDGE_INPUT_A(lines[3]), .EDGE_INPUT_B(lines[2]),
      .COMPARE_UNIT_FIRST_TRIGGER(lines[1]), .COMPARE_UNIT_SECOND_TRIGGER(lines[0]));
   ctu_edge_model pin_u (.clk(SYS_CLK), .rst(RST), .toggle(tog), .charge(CHARGE_ENABLE),
      .ground(SOURCE_GROUND), .lines(lines), .trip(COMPARATOR_TRIP));
   always #5 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [13:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      PSEL <= 1;
      PWRITE <= wr;
      PADDR <= {18'h0, a};
      PWDATA <= {24'h0, d};
      @(posedge SYS_CLK);
      PENABLE <= 1;
      do @(posedge SYS_CLK); while (PREADY !== 1'b1);
      rv = PRDATA[7:0];
      se = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   task automatic fire(input int k);
      @(posedge SYS_CLK);
      tog[k] <= 1;
      @(posedge SYS_CLK);
      tog <= 0;
      repeat (3) @(posedge SYS_CLK);
   endtask
   initial begin
      repeat (10) @(posedge SYS_CLK);
      RST <= 0;
      bus(0, LO, 0);
      `CHK(rv, CTU_RESET_VALUE)
      bus(0, HI, 0);
      `CHK(rv, CTU_RESET_VALUE)
      bus(1, 14'h3ED0, 8'hFF);
      `CHK(se, 1'b1)
      // reserved bit 0 written as one to prove it reads zero; unimplemented bit 6 written as zero
      bus(1, HI, 8'hBF);
      bus(0, HI, 0);
      `CHK(rv, 8'hBE)
      `CHK(SOURCE_GROUND, 1'b1)
      bus(1, HI, 8'h88);
      // rows with bit 0 clear set only the first flag; rows with bit 0 set start with it set and set the second
      foreach (rows[i]) begin
         w = rows[i][15:8];
         s = w[0] ? w[6:5] : w[3:2];
         p = w[0] ? w[7] : w[4];
         bus(1, LO, w);
         if (lines[s] == p) begin
            fire(s);
            bus(0, LO, 0);
            `CHK(rv, w)
         end
         fire(s);
         bus(0, LO, 0);
         `CHK(rv, rows[i][7:0])
         `CHK(CHARGE_ENABLE, ~w[0])
      end
      bus(1, HI, 8'h80);
      bus(1, LO, {~lines[3], 2'h3, ~lines[3], 2'h3, 2'h0});
      fire(3);
      bus(0, LO, 0);
      `CHK(rv[1:0], 2'h0)
      bus(1, HI, 8'h8C);
      bus(1, LO, {~lines[1], 2'h1, ~lines[0], 2'h0, 2'h0});
      fire(1);
      fire(0);
      bus(0, LO, 0);
      `CHK(rv[1:0], 2'h1)
      bus(1, LO, {~lines[1], 2'h1, ~lines[0], 2'h0, 2'h1});
      fire(1);
      bus(0, LO, 0);
      `CHK(rv[1:0], 2'h3)
      bus(1, HI, 8'h88);
      bus(1, LO, 8'h01);
      SLEEP_MODE <= 1;
      IDLE_MODE <= 1;
      repeat (2) @(posedge SYS_CLK);
      `CHK(CHARGE_ENABLE, 1'b0)
      SLEEP_MODE <= 0;
      repeat (3) @(posedge SYS_CLK);
      `CHK(CHARGE_ENABLE, 1'b1)
      bus(1, HI, 8'hA8);
      repeat (2) @(posedge SYS_CLK);
      `CHK(CHARGE_ENABLE, 1'b0)
      IDLE_MODE <= 0;
      bus(1, HI, 8'h9A);
      bus(1, HI, 8'h98);
      bus(1, LO, 8'h01);
      for (s = 0; s < 20 && PULSE_OUT_PIN !== 1'b1; s++) @(posedge SYS_CLK);
      `CHK(PULSE_OUT_PIN, 1'b1)
      bus(1, LO, 8'h00);
      repeat (2) @(posedge SYS_CLK);
      `CHK(PULSE_OUT_PIN, 1'b0)
      bus(1, LO, 8'h01);
      RST <= 1;
      @(posedge SYS_CLK);
      RST <= 0;
      @(posedge SYS_CLK);
      `CHK(CHARGE_ENABLE, 1'b0)
      bus(0, LO, 0);
      `CHK(rv, 8'h00)
      tally_and_finish();
   end
endmodule
`default_nettype wire
